// ===== design/fpc_pkg.sv
package fpc_pkg;
    // Register file addresses of the flash controller.
    localparam logic [11:0] TRIM_ADDR_OFS = 12'hff6;
    localparam logic [11:0] CMD_STAT_OFS  = 12'hff8;
    localparam logic [11:0] PAGE_PROT_OFS = 12'hff9;

    // Reset values.
    localparam logic [7:0] TRIM_RST = 8'h00;
    localparam logic [7:0] PROT_RST = 8'h00;
    localparam logic [7:0] PAGE_RST = 8'h00;

    // Command register values.
    localparam logic [7:0] CMD_IDLE     = 8'h00;
    localparam logic [7:0] CMD_SECT_SEL = 8'h5e;
    localparam logic [7:0] CMD_UNLOCK1  = 8'h73;
    localparam logic [7:0] CMD_UNLOCK2  = 8'h8c;
    localparam logic [7:0] CMD_PAGE_ERS = 8'h95;
    localparam logic [7:0] CMD_MASS_ERS = 8'h63;

    // Memory geometry: 8 KB, 512-byte pages, eight 1 KB sectors.
    localparam int ADDR_W  = 13;
    localparam int PAGE_LO = 9;
    localparam int PAGE_W  = 4;
    localparam int SECT_LO = 1;
    localparam int SECT_W  = 3;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // Status byte bit positions.
    localparam int ST_BUSY    = 7;
    localparam int ST_REFUSED = 6;
    localparam int ST_SECTSEL = 3;
    localparam int ST_LOCKED  = 2;
    localparam int ST_OPEN    = 1;
    localparam int ST_PROG_EN = 0;

    // Byte program time, rounded up to whole clock cycles.
    localparam int CLK_PERIOD_NS = 10;
    localparam int PROG_TIME_NS  = 40000;
    localparam int PROG_CYC      =
        (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W         = 12;

    typedef enum logic [2:0] {
        ST_LOCK,
        ST_UNLK1,
        ST_UNLK2,
        ST_PAGE_OPEN,
        ST_ERS_PAGE,
        ST_ERS_MASS,
        ST_SECT
    } fpc_state_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic        dbg;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } fpc_reg_req_t;

    typedef struct packed {
        logic              valid;
        logic              dbg;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
    } fpc_prog_req_t;
endpackage

// ===== design/fpc_flash_ctrl.sv
`timescale 1ns/1ps
module fpc_flash_ctrl
    import fpc_pkg::*;
(
    input  wire logic                  clock_i,
    input  wire logic                  srst_i,
    input  wire fpc_pkg::fpc_reg_req_t reg_req_i,
    output logic [7:0]                 reg_rdata_o,
    input  wire fpc_pkg::fpc_prog_req_t prog_req_i,
    input  wire logic                  bypass_i,
    input  wire logic [7:0]            flash_rdata_i,
    output logic                       cpu_stall_o,
    output logic                       flash_we_o,
    output logic [12:0]                flash_addr_o,
    output logic [7:0]                 flash_wdata_o,
    output logic                       erase_page_o,
    output logic                       erase_mass_o,
    output logic [3:0]                 erase_page_sel_o,
    output logic [7:0]                 trim_option_address_o
);
    import fpc_pkg::*;

    fpc_state_t        state_q, state_d;
    logic [7:0]        prot_q;
    logic [7:0]        page_q;
    logic [7:0]        trim_q;
    logic [CNT_W-1:0]  cnt_q;
    logic              stall_q;
    logic              refused_q;
    logic [7:0]        rdata_q;
    logic              we_q;
    logic [12:0]       waddr_q;
    logic [7:0]        wdata_q;
    logic              ers_page_q;
    logic              ers_mass_q;

    // Register access decode.
    wire cmd_wr   = reg_req_i.wr && (reg_req_i.addr == CMD_STAT_OFS);
    wire pp_wr    = reg_req_i.wr && (reg_req_i.addr == PAGE_PROT_OFS);
    wire trim_wr  = reg_req_i.wr && (reg_req_i.addr == TRIM_ADDR_OFS);
    wire sect_sel = (state_q == ST_SECT);
    wire prot_wr  = pp_wr && sect_sel;
    wire page_wr  = pp_wr && !sect_sel;
    wire [7:0] cmd = reg_req_i.wdata;

    wire [PAGE_W-1:0] open_page = page_q[PAGE_W-1:0];
    wire [SECT_W-1:0] open_sect = open_page[SECT_LO +: SECT_W];
    wire erasing_ok  = (state_q == ST_PAGE_OPEN) ||
                       (state_q == ST_ERS_PAGE) ||
                       (state_q == ST_ERS_MASS);
    // Erase of a protected sector is refused for the processor only.
    wire page_ers_ok = erasing_ok &&
                       (!prot_q[open_sect] || reg_req_i.dbg);
    // Mass erase is a debugger-only command.
    wire mass_ers_ok = erasing_ok && reg_req_i.dbg;

    // Byte program acceptance.
    wire [PAGE_W-1:0] req_page = prog_req_i.addr[PAGE_LO +: PAGE_W];
    wire [SECT_W-1:0] req_sect = req_page[SECT_LO +: SECT_W];
    wire prot_exempt = prog_req_i.dbg || bypass_i;
    wire prot_clear  = prot_exempt || !prot_q[req_sect];
    wire in_scope    = (state_q == ST_ERS_MASS) ||
                       ((state_q == ST_ERS_PAGE) && (req_page == open_page));
    wire prog_start  = prog_req_i.valid && !stall_q && in_scope &&
                       prot_clear;
    wire prog_refuse = prog_req_i.valid && !prog_start;
    wire [7:0] new_byte = flash_rdata_i & prog_req_i.data;

    wire [7:0] status = {stall_q, refused_q, 2'h0, sect_sel,
                         (state_q == ST_LOCK), erasing_ok,
                         (state_q == ST_ERS_PAGE) ||
                         (state_q == ST_ERS_MASS)};
    wire [7:0] rd_mux =
        (reg_req_i.addr == CMD_STAT_OFS)  ? status :
        (reg_req_i.addr == PAGE_PROT_OFS) ? (sect_sel ? prot_q : page_q) :
        (reg_req_i.addr == TRIM_ADDR_OFS) ? trim_q : 8'h00;
    wire [7:0] rdata_d = reg_req_i.rd ? rd_mux : 8'h00;

    // Command sequencer; a command write outranks a page write.
    always_comb begin
        state_d = state_q;
        if (cmd_wr) begin
            state_d = ST_LOCK;
            case (cmd)
                CMD_UNLOCK1: begin
                    if (state_q == ST_LOCK)
                        state_d = ST_UNLK1;
                end
                CMD_UNLOCK2: begin
                    if (state_q == ST_UNLK1)
                        state_d = ST_UNLK2;
                end
                CMD_SECT_SEL: begin
                    if (state_q == ST_LOCK)
                        state_d = ST_SECT;
                end
                CMD_PAGE_ERS: begin
                    if (page_ers_ok)
                        state_d = ST_ERS_PAGE;
                end
                CMD_MASS_ERS: begin
                    if (mass_ers_ok)
                        state_d = ST_ERS_MASS;
                end
                default: state_d = ST_LOCK;
            endcase
        end else if (page_wr && state_q == ST_UNLK2) begin
            state_d = (reg_req_i.wdata == page_q) ? ST_PAGE_OPEN : ST_LOCK;
        end else if (page_wr && state_q != ST_LOCK) begin
            state_d = ST_LOCK;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i)
            state_q <= ST_LOCK;
        else
            state_q <= state_d;
    end

    always_ff @(posedge clock_i) begin
        if (srst_i)
            prot_q <= PROT_RST;
        else if (prot_wr)
            prot_q <= prot_q | reg_req_i.wdata;
    end

    // The first page write of an unlock is stored; the rewrite is compared.
    always_ff @(posedge clock_i) begin
        if (srst_i)
            page_q <= PAGE_RST;
        else if (page_wr && state_q == ST_LOCK)
            page_q <= reg_req_i.wdata;
    end

    always_ff @(posedge clock_i) begin
        if (srst_i)
            trim_q <= TRIM_RST;
        else if (trim_wr)
            trim_q <= reg_req_i.wdata;
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            stall_q <= 1'b0;
            cnt_q   <= '0;
        end else if (prog_start) begin
            stall_q <= 1'b1;
            cnt_q   <= CNT_W'(PROG_CYC - 1);
        end else if (stall_q) begin
            stall_q <= (cnt_q != '0);
            cnt_q   <= cnt_q - CNT_W'(1);
        end
    end

    // A refused request is sticky until the next command; a new refusal
    // in the same cycle as the command write wins.
    always_ff @(posedge clock_i) begin
        if (srst_i)
            refused_q <= 1'b0;
        else
            refused_q <= prog_refuse || (refused_q && !cmd_wr);
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            we_q    <= 1'b0;
            waddr_q <= '0;
            wdata_q <= ERASED_BYTE;
        end else begin
            we_q <= prog_start;
            if (prog_start) begin
                waddr_q <= prog_req_i.addr;
                wdata_q <= new_byte;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            ers_page_q <= 1'b0;
            ers_mass_q <= 1'b0;
            rdata_q    <= 8'h00;
        end else begin
            ers_page_q <= cmd_wr && cmd == CMD_PAGE_ERS && page_ers_ok;
            ers_mass_q <= cmd_wr && cmd == CMD_MASS_ERS && mass_ers_ok;
            rdata_q    <= rdata_d;
        end
    end

    assign cpu_stall_o           = stall_q;
    assign flash_we_o            = we_q;
    assign flash_addr_o          = waddr_q;
    assign flash_wdata_o         = wdata_q;
    assign erase_page_o          = ers_page_q;
    assign erase_mass_o          = ers_mass_q;
    assign erase_page_sel_o      = open_page;
    assign trim_option_address_o = trim_q;
    assign reg_rdata_o           = rdata_q;

    // Helper for the stall checks: the program time is far too long for a
    // repetition, so the length of each stall is counted here instead.
    logic [CNT_W-1:0] stall_run_q;

    always_ff @(posedge clock_i) begin
        if (srst_i)
            stall_run_q <= '0;
        else if (cpu_stall_o)
            stall_run_q <= stall_run_q + CNT_W'(1);
        else
            stall_run_q <= '0;
    end

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (srst_i);

    prot_sticky_a: assert property (
        (prot_q & $past(prot_q)) == $past(prot_q))
        else $error("A sector protection bit was cleared.");
    prot_or_a: assert property (
        prot_wr |=> prot_q == ($past(prot_q) | $past(reg_req_i.wdata)))
        else $error("Protect write did not OR in the data.");
    prot_block_a: assert property (
        prog_start && !prog_req_i.dbg && !bypass_i |-> !prot_q[req_sect])
        else $error("Processor programmed a protected sector.");
    prog_gate_a: assert property (
        $rose(flash_we_o) |-> $past(state_q == ST_ERS_PAGE ||
                                    state_q == ST_ERS_MASS))
        else $error("Programming started without a prior erase.");
    page_scope_a: assert property (
        prog_start && state_q == ST_ERS_PAGE |-> req_page == open_page)
        else $error("Programming outside the erased page.");
    clear_only_a: assert property (
        prog_start |=> (flash_wdata_o & ~$past(flash_rdata_i)) == 8'h00)
        else $error("Programming would set a bit to one.");
    stall_start_a: assert property (
        prog_start |=> cpu_stall_o && stall_run_q == '0)
        else $error("Stall did not start with the program.");
    stall_hold_a: assert property (
        $fell(cpu_stall_o) |-> stall_run_q == CNT_W'(PROG_CYC))
        else $error("Stall did not cover the program time.");
    stall_cap_a: assert property (
        stall_run_q <= CNT_W'(PROG_CYC))
        else $error("Stall outlasted the program time.");
    lock_cmd_a: assert property (
        cmd_wr && cmd != CMD_PAGE_ERS && cmd != CMD_MASS_ERS &&
        cmd != CMD_UNLOCK1 && cmd != CMD_UNLOCK2 && cmd != CMD_SECT_SEL
        |=> state_q == ST_LOCK)
        else $error("Non-erase command did not lock.");
    page_cmp_a: assert property (
        state_q == ST_UNLK2 && page_wr && !cmd_wr &&
        reg_req_i.wdata != page_q |=> state_q == ST_LOCK)
        else $error("Page mismatch did not lock.");
    erase_prot_a: assert property (
        erase_page_o |-> !prot_q[open_sect] || $past(reg_req_i.dbg))
        else $error("Page erase of a protected sector.");

    cov_page_prog_c: cover property (
        state_q == ST_ERS_PAGE ##[1:20] $rose(flash_we_o));
    cov_sect_set_c: cover property (prot_wr && reg_req_i.wdata != 8'h00);
    cov_refused_c: cover property (prog_refuse && state_q == ST_LOCK);
    cov_mass_prog_c: cover property (state_q == ST_ERS_MASS && prog_start);
endmodule

// ===== testbench/fpc_flash_model.sv
`timescale 1ns/1ps
// Behavioural flash array that sits behind the controller's array port.
module fpc_flash_model
    import fpc_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        we_i,
    input  wire logic [12:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        ers_page_i,
    input  wire logic        ers_mass_i,
    input  wire logic [3:0]  page_sel_i,
    input  wire logic [12:0] rd_addr_i,
    output logic [7:0]       rdata_o
);
    logic [7:0] mem [0:8191];

    initial begin
        for (int i = 0; i < 8192; i++) mem[i] = ERASED_BYTE;
    end

    // cells only clear
    // The AND keeps a faulty wdata from ever setting a cell back to one.
    always @(posedge clock_i) begin
        if (ers_mass_i)
            for (int i = 0; i < 8192; i++) mem[i] = ERASED_BYTE;
        if (ers_page_i)
            for (int i = 0; i < 512; i++)
                mem[{page_sel_i, 9'h000} + i] = ERASED_BYTE;
        if (we_i)
            mem[addr_i] = mem[addr_i] & wdata_i;
    end

    assign rdata_o = mem[rd_addr_i];
endmodule

// ===== testbench/flash_program_protect_ctrl_bench.sv
`timescale 1ns/1ps
module flash_program_protect_ctrl_bench;
    import fpc_pkg::*;
    logic          clock_i = 1'b0;
    logic          srst_i  = 1'b1;
    fpc_reg_req_t  rq      = '0;
    fpc_prog_req_t pq      = '0;
    logic          byp     = 1'b0;
    logic [7:0]    rdata, frd, fwd, trim;
    logic [12:0]   fad;
    logic [3:0]    psel;
    logic          stall, we, ep, em;
    int            fail_count   = 0;
    int            total_checks = 0;
    int            cyc = 0, n_ep = 0, n_em = 0;

    initial forever #5 clock_i = ~clock_i;

    fpc_flash_ctrl u_dut (
        .clock_i(clock_i), .srst_i(srst_i), .reg_req_i(rq),
        .reg_rdata_o(rdata), .prog_req_i(pq), .bypass_i(byp),
        .flash_rdata_i(frd), .cpu_stall_o(stall), .flash_we_o(we),
        .flash_addr_o(fad), .flash_wdata_o(fwd), .erase_page_o(ep),
        .erase_mass_o(em), .erase_page_sel_o(psel),
        .trim_option_address_o(trim));

    fpc_flash_model u_arr (
        .clock_i(clock_i), .we_i(we), .addr_i(fad), .wdata_i(fwd),
        .ers_page_i(ep), .ers_mass_i(em), .page_sel_i(psel),
        .rd_addr_i(pq.addr), .rdata_o(frd));

    task automatic report_and_stop();
        if (fail_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Four byte programs of 4000 cycles each fit well inside this ceiling.
    always @(posedge clock_i) begin
        cyc++;
        n_ep += ep;
        n_em += em;
        if (cyc == 40000) begin
            fail_count++;
            report_and_stop();
        end
    end

    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic wr(logic [11:0] a, logic [7:0] d, logic g = 1'b0);
        @(negedge clock_i);
        rq = {1'b1, 1'b0, g, a, d};
        @(negedge clock_i);
        rq = '0;
    endtask

    task automatic rd(logic [11:0] a, logic [7:0] e, string nm);
        @(negedge clock_i);
        rq = {1'b0, 1'b1, 1'b0, a, 8'h00};
        @(negedge clock_i);
        rq = '0;
        chk(nm, {8'h00, e}, {8'h00, rdata});
    endtask

    task automatic unlock(logic [7:0] p, logic [7:0] q);
        wr(12'hff8, 8'h00);
        wr(12'hff9, p);
        wr(12'hff8, 8'h73);
        wr(12'hff8, 8'h8c);
        wr(12'hff9, q);
    endtask

    // Stall length is counted on falling edges, so it is exact to a cycle.
    task automatic prog(logic g, logic [12:0] a, logic [7:0] d, logic ok,
                        logic [7:0] e);
        int k = 0;
        @(negedge clock_i);
        pq = {1'b1, g, a, d};
        @(negedge clock_i);
        pq = '0;
        chk("we", {15'h0000, ok}, {15'h0000, we});
        if (ok) begin
            chk("addr", {3'h0, a}, {3'h0, fad});
            chk("wdata", {8'h00, e}, {8'h00, fwd});
            while (stall === 1'b1 && k < 5000) begin
                k++;
                @(negedge clock_i);
            end
            chk("stall_len", 16'h0fa0, k[15:0]);
        end else
            chk("stall", 16'h0000, {15'h0000, stall});
    endtask

    initial begin
        repeat (3) @(posedge clock_i);
        @(negedge clock_i);
        srst_i = 1'b0;
        rd(12'hff6, 8'h00, "trim");
        rd(12'hff8, 8'h04, "status");
        rd(12'hf00, 8'h00, "unmapped");
        wr(12'hff6, 8'h1f);
        rd(12'hff6, 8'h1f, "trim");
        chk("trim_o", 16'h001f, {8'h00, trim});
        wr(12'hff8, 8'h00);
        wr(12'hff8, 8'h5e);
        rd(12'hff9, 8'h00, "protect");
        wr(12'hff9, 8'h02);
        wr(12'hff9, 8'h04);
        wr(12'hff9, 8'h00);
        rd(12'hff9, 8'h06, "protect");
        unlock(8'h00, 8'h00);
        rd(12'hff8, 8'h02, "status");
        wr(12'hff8, 8'h95);
        rd(12'hff8, 8'h03, "status");
        chk("page_erase", 16'h0001, n_ep[15:0]);
        prog(1'b0, 13'h0005, 8'h5a, 1'b1, 8'h5a);
        prog(1'b0, 13'h0005, 8'hf0, 1'b1, 8'h50);
        prog(1'b0, 13'h0205, 8'h00, 1'b0, 8'h00);
        rd(12'hff8, 8'h43, "status");
        wr(12'hff8, 8'h00);
        prog(1'b0, 13'h0006, 8'h00, 1'b0, 8'h00);
        unlock(8'h02, 8'h02);
        wr(12'hff8, 8'h95);
        unlock(8'h01, 8'h03);
        chk("page_erase", 16'h0001, n_ep[15:0]);
        wr(12'hff8, 8'h95);
        unlock(8'h00, 8'h00);
        chk("page_erase", 16'h0001, n_ep[15:0]);
        wr(12'hff8, 8'h11);
        wr(12'hff8, 8'h95);
        unlock(8'h00, 8'h00);
        chk("page_erase", 16'h0001, n_ep[15:0]);
        wr(12'hff8, 8'h63, 1'b1);
        prog(1'b0, 13'h0400, 8'h00, 1'b0, 8'h00);
        chk("mass_erase", 16'h0001, n_em[15:0]);
        prog(1'b1, 13'h0400, 8'h0f, 1'b1, 8'h0f);
        byp = 1'b1;
        prog(1'b0, 13'h0401, 8'h33, 1'b1, 8'h33);
        byp = 1'b0;
        report_and_stop();
    end
endmodule
